// *** include/region_protection_params.svh ***
`ifndef REGION_PROTECTION_PARAMS_SVH
`define REGION_PROTECTION_PARAMS_SVH
// register byte addresses
`define ADDR_TYPE_INFO 32'he000ed90
`define ADDR_CONTROL 32'he000ed94
`define ADDR_REGION_SELECT 32'he000ed98
`define ADDR_REGION_BASE 32'he000ed9c
`define ADDR_REGION_ATTR 32'he000eda0
`define ADDR_BASE_ALIAS_ONE 32'he000eda4
`define ADDR_ATTR_ALIAS_ONE 32'he000eda8
`define ADDR_BASE_ALIAS_TWO 32'he000edac
`define ADDR_ATTR_ALIAS_TWO 32'he000edb0
`define ADDR_BASE_ALIAS_THREE 32'he000edb4
`define ADDR_ATTR_ALIAS_THREE 32'he000edb8
`define ADDR_IRQ_STATUS 32'he000edc0
`define ADDR_IRQ_MASK 32'he000edc4
// reset values
`define TYPE_INFO_VALUE 32'h00000800
`define CONTROL_RESET 3'h0
`define REGION_RESET 32'h00000000
// control bits
`define CTRL_ENABLE_BIT 0
`define CTRL_FAULT_HANDLER_BIT 1
`define CTRL_DEFAULT_MAP_BIT 2
// base register fields
`define BASE_VALID_BIT 4
`define BASE_ADDR_MASK 32'hffffffe0
// attribute-and-size fields
`define ATTR_WRITE_MASK 32'h173fff3f
`define ATTR_XN_BIT 28
`define ATTR_AP_LSB 24
`define ATTR_TEX_LSB 19
`define ATTR_S_BIT 18
`define ATTR_C_BIT 17
`define ATTR_B_BIT 16
`define ATTR_SRD_LSB 8
`define ATTR_SIZE_LSB 1
`define ATTR_EN_BIT 0
`define SIZE_WHOLE_MAP 5'h1f
`define SIZE_MIN_SUBREGION 5'h07
// system control space window
`define SCS_BASE 32'he000e000
`define SCS_MASK 32'hfffff000
`define NUM_REGIONS 8
`define NUM_EVENTS 2
`endif

// *** include/region_protection_pkg.sv ***
package region_protection_pkg;
  typedef enum logic [1:0] {
    MT_STRONG = 2'h0,
    MT_DEVICE = 2'h1,
    MT_NORMAL = 2'h2
  } mem_type_t;
  typedef struct packed {
    mem_type_t mem_type;
    logic shareable;
    logic ordered;
    logic cacheable;
    logic bufferable;
    logic [2:0] tex;
    logic xn;
    logic background;
    logic [2:0] region_num;
  } attr_t;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic instr;
    logic priv;
    logic vector_fetch;
    logic neg_priority;
  } acc_req_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;
  typedef enum logic [3:0] {
    SEL_NONE, SEL_TYPE, SEL_CTRL, SEL_RSEL, SEL_BASE, SEL_ATTR, SEL_STAT, SEL_MASK
  } reg_sel_t;
endpackage : region_protection_pkg

// *** verilog/region_protection_unit.sv ***
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "region_protection_params.svh"
module region_protection_unit (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // axi4-lite write
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core access check
  input wire logic acc_valid,
  input wire region_protection_pkg::acc_req_t acc_req,
  output logic chk_valid,
  output logic chk_fault,
  output region_protection_pkg::attr_t chk_attr,
  // interrupt
  output logic irq
);
  localparam int NR = `NUM_REGIONS;
  logic [2:0] ctrl_r;
  logic [2:0] rsel_r;
  logic [31:0] base_r [NR];
  logic [31:0] rattr_r [NR];
  logic [`NUM_EVENTS-1:0] status_r;
  logic [`NUM_EVENTS-1:0] mask_r;
  region_protection_pkg::wr_state_t wr_state_r, wr_state_nxt;
  logic aw_got_r, w_got_r, aw_got_nxt, w_got_nxt;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wa_r, wd_r;
  logic [3:0] ws_r;
  logic wp_r;
  logic aw_take, w_take, wr_do, ar_take, rvalid_nxt;
  logic chk_valid_r, chk_fault_r;
  region_protection_pkg::attr_t chk_attr_r;

  function automatic region_protection_pkg::reg_sel_t decode(input logic [31:0] a);
    unique case (a)
      `ADDR_TYPE_INFO: decode = region_protection_pkg::SEL_TYPE;
      `ADDR_CONTROL: decode = region_protection_pkg::SEL_CTRL;
      `ADDR_REGION_SELECT: decode = region_protection_pkg::SEL_RSEL;
      `ADDR_REGION_BASE, `ADDR_BASE_ALIAS_ONE, `ADDR_BASE_ALIAS_TWO,
      `ADDR_BASE_ALIAS_THREE: decode = region_protection_pkg::SEL_BASE;
      `ADDR_REGION_ATTR, `ADDR_ATTR_ALIAS_ONE, `ADDR_ATTR_ALIAS_TWO,
      `ADDR_ATTR_ALIAS_THREE: decode = region_protection_pkg::SEL_ATTR;
      `ADDR_IRQ_STATUS: decode = region_protection_pkg::SEL_STAT;
      `ADDR_IRQ_MASK: decode = region_protection_pkg::SEL_MASK;
      default: decode = region_protection_pkg::SEL_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  // fixed map attributes, used for background and disabled unit
  function automatic region_protection_pkg::attr_t def_attr(input logic [31:0] a);
    region_protection_pkg::attr_t t;
    t = '0;
    t.background = 1'b1;
    unique case (a[31:29])
      3'h0, 3'h1, 3'h3, 3'h4: begin
        t.mem_type = region_protection_pkg::MT_NORMAL;
        t.cacheable = 1'b1;
      end
      3'h7: begin
        t.mem_type = region_protection_pkg::MT_STRONG;
        t.xn = 1'b1;
      end
      default: begin
        t.mem_type = region_protection_pkg::MT_DEVICE;
        t.bufferable = 1'b1;
        t.xn = 1'b1;
      end
    endcase
    if (t.mem_type == region_protection_pkg::MT_STRONG) begin
      t.ordered = 1'b1;
      t.shareable = 1'b1;
    end
    def_attr = t;
  endfunction : def_attr

  function automatic region_protection_pkg::attr_t reg_attr(input logic [31:0] r,
                                                           input logic [2:0] n);
    region_protection_pkg::attr_t t;
    logic [2:0] tex;
    tex = r[`ATTR_TEX_LSB +: 3];
    t = '0;
    t.tex = tex;
    t.cacheable = r[`ATTR_C_BIT];
    t.bufferable = r[`ATTR_B_BIT];
    t.xn = r[`ATTR_XN_BIT];
    t.region_num = n;
    t.shareable = r[`ATTR_S_BIT];
    if (tex == 3'h0 && !r[`ATTR_C_BIT] && !r[`ATTR_B_BIT]) begin
      t.mem_type = region_protection_pkg::MT_STRONG;
      t.ordered = 1'b1;
      t.shareable = 1'b1;
    end else if (tex == 3'h0 && !r[`ATTR_C_BIT]) begin
      t.mem_type = region_protection_pkg::MT_DEVICE;
      t.shareable = 1'b1;
    end else if (tex == 3'h2 && !r[`ATTR_C_BIT] && !r[`ATTR_B_BIT]) begin
      t.mem_type = region_protection_pkg::MT_DEVICE;
      t.shareable = 1'b0;
    end else begin
      t.mem_type = region_protection_pkg::MT_NORMAL;
    end
    reg_attr = t;
  endfunction : reg_attr

  function automatic logic region_hit(input logic [31:0] b, input logic [31:0] r,
                                      input logic [31:0] a);
    logic [4:0] sz;
    logic [31:0] m;
    logic [2:0] sub;
    sz = r[`ATTR_SIZE_LSB +: 5];
    m = (sz == `SIZE_WHOLE_MAP) ? 32'h0 : (32'hffffffff << (sz + 5'h1));
    sub = 3'(a >> (sz - 5'h2));
    region_hit = r[`ATTR_EN_BIT] && ((a & m) == (b & m));
    // small regions carry no subregions
    if (sz >= `SIZE_MIN_SUBREGION && r[`ATTR_SRD_LSB + sub]) begin
      region_hit = 1'b0;
    end
  endfunction : region_hit

  function automatic logic ap_ok(input logic [2:0] ap, input logic priv, input logic wr);
    unique case (ap)
      3'h1: ap_ok = priv;
      3'h2: ap_ok = priv || !wr;
      3'h3: ap_ok = 1'b1;
      3'h5: ap_ok = priv && !wr;
      3'h6, 3'h7: ap_ok = !wr;
      default: ap_ok = 1'b0;
    endcase
  endfunction : ap_ok

  // one compare per region, all in the same cycle
  logic [NR-1:0] hit_vec;
  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_cmp
      assign hit_vec[g] = region_hit(base_r[g], rattr_r[g], acc_req.addr);
    end
  endgenerate

  logic [2:0] top_idx;
  logic any_hit, prot_on, free_zone, fault_nxt;
  region_protection_pkg::attr_t attr_nxt;
  always_comb begin
    top_idx = 3'h0;
    for (int i = 0; i < NR; i++) begin
      if (hit_vec[i]) begin
        top_idx = 3'(i);
      end
    end
    any_hit = |hit_vec;
    prot_on = ctrl_r[`CTRL_ENABLE_BIT] &&
              (!acc_req.neg_priority || ctrl_r[`CTRL_FAULT_HANDLER_BIT]);
    free_zone = ((acc_req.addr & `SCS_MASK) == `SCS_BASE) || acc_req.vector_fetch;
    attr_nxt = def_attr(acc_req.addr);
    fault_nxt = 1'b0;
    if (prot_on) begin
      if (any_hit) begin
        attr_nxt = reg_attr(rattr_r[top_idx], top_idx);
        fault_nxt = !ap_ok(rattr_r[top_idx][`ATTR_AP_LSB +: 3], acc_req.priv,
                           acc_req.write) || (acc_req.instr && attr_nxt.xn);
      end else begin
        // background only for privileged code with default map on
        fault_nxt = !(acc_req.priv && ctrl_r[`CTRL_DEFAULT_MAP_BIT]);
      end
      if (free_zone) begin
        fault_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chk_valid_r <= 1'b0;
      chk_fault_r <= 1'b0;
      chk_attr_r <= '0;
    end else begin
      chk_valid_r <= acc_valid;
      chk_fault_r <= acc_valid && fault_nxt;
      chk_attr_r <= attr_nxt;
    end
  end

  // write channel: address and data latched independently
  always_comb begin
    aw_take = awvalid && awready_r;
    w_take = wvalid && wready_r;
    wr_do = (wr_state_r == region_protection_pkg::WR_IDLE) && aw_got_r && w_got_r;
    aw_got_nxt = !wr_do && (aw_got_r || aw_take);
    w_got_nxt = !wr_do && (w_got_r || w_take);
    wr_state_nxt = wr_state_r;
    unique case (wr_state_r)
      region_protection_pkg::WR_IDLE: begin
        if (wr_do) begin
          wr_state_nxt = region_protection_pkg::WR_RESP;
        end
      end
      region_protection_pkg::WR_RESP: begin
        if (bready) begin
          wr_state_nxt = region_protection_pkg::WR_IDLE;
        end
      end
      default: wr_state_nxt = region_protection_pkg::WR_IDLE;
    endcase
  end

  region_protection_pkg::reg_sel_t wsel;
  assign wsel = decode(wa_r);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_state_r <= region_protection_pkg::WR_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      wa_r <= 32'h0;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      wp_r <= 1'b0;
    end else begin
      wr_state_r <= wr_state_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= !aw_got_nxt && (wr_state_nxt == region_protection_pkg::WR_IDLE);
      wready_r <= !w_got_nxt && (wr_state_nxt == region_protection_pkg::WR_IDLE);
      bvalid_r <= (wr_state_nxt == region_protection_pkg::WR_RESP);
      if (aw_take) begin
        wa_r <= awaddr;
        wp_r <= awprot[0];
      end
      if (w_take) begin
        wd_r <= wdata;
        ws_r <= wstrb;
      end
      if (wr_do) begin
        bresp_r <= (wsel == region_protection_pkg::SEL_NONE) ? 2'h3 :
                   (!wp_r ? 2'h2 : 2'h0);
      end
    end
  end

  logic wr_ok;
  logic [31:0] base_wr, ctrl_wr, rsel_wr, mask_wr;
  assign wr_ok = wr_do && wp_r;
  assign base_wr = merge(base_r[rsel_r], wd_r, ws_r);
  // merged words first, since a call result cannot be part-selected
  assign ctrl_wr = merge({29'h0, ctrl_r}, wd_r, ws_r);
  assign rsel_wr = merge({29'h0, rsel_r}, wd_r, ws_r);
  assign mask_wr = merge({30'h0, mask_r}, wd_r, ws_r);

  // control, irq mask, region set and selector
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `CONTROL_RESET;
      rsel_r <= 3'h0;
      mask_r <= '0;
      for (int i = 0; i < NR; i++) begin
        base_r[i] <= `REGION_RESET;
        rattr_r[i] <= `REGION_RESET;
      end
    end else if (wr_ok) begin
      unique case (wsel)
        region_protection_pkg::SEL_CTRL: ctrl_r <= ctrl_wr[2:0];
        region_protection_pkg::SEL_RSEL: rsel_r <= rsel_wr[2:0];
        region_protection_pkg::SEL_MASK: begin
          mask_r <= mask_wr[`NUM_EVENTS-1:0];
        end
        region_protection_pkg::SEL_BASE: begin
          // valid bit retargets the selector along with the base
          if (base_wr[`BASE_VALID_BIT]) begin
            rsel_r <= base_wr[2:0];
            base_r[base_wr[2:0]] <= base_wr & `BASE_ADDR_MASK;
          end else begin
            base_r[rsel_r] <= base_wr & `BASE_ADDR_MASK;
          end
        end
        region_protection_pkg::SEL_ATTR: begin
          rattr_r[rsel_r] <= merge(rattr_r[rsel_r], wd_r, ws_r) & `ATTR_WRITE_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // sticky fault events, set beats a simultaneous clear
  logic [`NUM_EVENTS-1:0] ev_set, ev_clr;
  always_comb begin
    ev_set = {acc_valid && fault_nxt && acc_req.instr, acc_valid && fault_nxt && !acc_req.instr};
    ev_clr = (wr_ok && wsel == region_protection_pkg::SEL_STAT) ?
             (wd_r[`NUM_EVENTS-1:0] & {`NUM_EVENTS{ws_r[0]}}) : '0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= (status_r & ~ev_clr) | ev_set;
      irq_r <= |(status_r & mask_r);
    end
  end

  // read channel, data one cycle after the address is taken
  region_protection_pkg::reg_sel_t rsel_dec;
  logic [31:0] rd_val;
  assign ar_take = arvalid && arready_r;
  assign rvalid_nxt = ar_take || (rvalid_r && !rready);
  assign rsel_dec = decode(araddr);
  always_comb begin
    unique case (rsel_dec)
      region_protection_pkg::SEL_TYPE: rd_val = `TYPE_INFO_VALUE;
      region_protection_pkg::SEL_CTRL: rd_val = {29'h0, ctrl_r};
      region_protection_pkg::SEL_RSEL: rd_val = {29'h0, rsel_r};
      region_protection_pkg::SEL_BASE: rd_val = base_r[rsel_r] | {29'h0, rsel_r};
      region_protection_pkg::SEL_ATTR: rd_val = rattr_r[rsel_r];
      region_protection_pkg::SEL_STAT: rd_val = {30'h0, status_r};
      region_protection_pkg::SEL_MASK: rd_val = {30'h0, mask_r};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        // unprivileged reads see zero and an error
        rdata_r <= arprot[0] ? rd_val : 32'h0;
        rresp_r <= (rsel_dec == region_protection_pkg::SEL_NONE) ? 2'h3 :
                   (!arprot[0] ? 2'h2 : 2'h0);
      end
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign chk_valid = chk_valid_r;
  assign chk_fault = chk_fault_r;
  assign chk_attr = chk_attr_r;
  assign irq = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_TYPE_READ: assert property (ar_take && rsel_dec == region_protection_pkg::SEL_TYPE &&
    arprot[0] |=> rvalid_r && rdata_r == 32'h00000800 && rdata_r[23:16] == 8'h00)
    else $error("type register read wrong");
  AST_DISABLED: assert property (acc_valid && !ctrl_r[0] |=> chk_valid_r && !chk_fault_r &&
    chk_attr_r.background) else $error("disabled unit faulted");
  AST_UNPRIV_MISS: assert property (acc_valid && ctrl_r[0] && !acc_req.neg_priority &&
    hit_vec == '0 && !acc_req.priv && !free_zone |=> chk_fault_r)
    else $error("unprivileged miss not faulted");
  AST_PRIV_BG: assert property (acc_valid && ctrl_r == 3'h5 && hit_vec == '0 &&
    acc_req.priv |=> !chk_fault_r && chk_attr_r.background) else $error("background refused");
  AST_HIGHEST: assert property (acc_valid && ctrl_r[0] && !acc_req.neg_priority &&
    hit_vec[7] |=> chk_attr_r.region_num == 3'h7 && !chk_attr_r.background)
    else $error("lower region won overlap");
  AST_BYPASS: assert property (acc_valid && ctrl_r[0] && !ctrl_r[1] &&
    acc_req.neg_priority |=> !chk_fault_r) else $error("no bypass in high handler");
  AST_FREE_ZONE: assert property (acc_valid && ctrl_r[0] && free_zone |=> !chk_fault_r)
    else $error("control space access faulted");
  AST_STRONG_SHARED: assert property (chk_valid_r &&
    chk_attr_r.mem_type == region_protection_pkg::MT_STRONG |-> chk_attr_r.shareable &&
    chk_attr_r.ordered) else $error("strongly-ordered not shared");
  AST_FAULT_STICKY: assert property (chk_fault_r |-> status_r != '0 ##1
    (status_r != '0 || $past(ev_clr) != '0)) else $error("fault event lost");
  AST_IRQ: assert property ((status_r & mask_r) != '0 |=> irq_r) else $error("irq not raised");
  AST_WRITE_RESP: assert property (wr_do |=> bvalid_r &&
    bresp_r == ($past(wsel == region_protection_pkg::SEL_NONE) ? 2'h3 :
                ($past(wp_r) ? 2'h0 : 2'h2)))
    else $error("write response missing");

  COV_FAULT: cover property (acc_valid && fault_nxt ##1 chk_fault_r);
  COV_OVERLAP: cover property (acc_valid && $countones(hit_vec) > 1);
  COV_WRITE: cover property (bvalid_r && bready && bresp_r == 2'h0);
  COV_IRQ: cover property ($rose(irq_r));
endmodule : region_protection_unit

// *** test/core_access_model.sv ***
`timescale 1ns/1ps
module core_access_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // access request towards the unit
  output logic acc_valid,
  output region_protection_pkg::acc_req_t acc_req,
  // check result from the unit
  input wire logic chk_valid,
  input wire logic chk_fault,
  input wire region_protection_pkg::attr_t chk_attr
);
  initial begin
    acc_valid = 1'b0;
    acc_req = '0;
  end

  // one access per call; the result is registered, so it is read one edge later
  task automatic issue(input region_protection_pkg::acc_req_t r, output logic v,
                       output logic f, output region_protection_pkg::attr_t a);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_req <= r;
    @(posedge clk);
    acc_valid <= 1'b0;
    // stale request is not left on the bus
    acc_req <= ~r;
    #1;
    v = chk_valid;
    f = chk_fault;
    a = chk_attr;
  endtask : issue
endmodule : core_access_model

// *** test/tb_region_protection_unit.sv ***
`timescale 1ns/1ps
`include "region_protection_params.svh"
module tb_region_protection_unit;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, acc_valid, chk_valid, chk_fault, irq;
  logic [1:0] bresp, rresp, rs;
  region_protection_pkg::acc_req_t acc_req;
  region_protection_pkg::attr_t chk_attr, at;
  int err_count = 0, checks_done = 0, cycles = 0;

  always #4 clk = ~clk;

  region_protection_unit u_region_protection_unit (
    .clk(clk), .arst_n(arst_n),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .acc_valid(acc_valid), .acc_req(acc_req), .chk_valid(chk_valid),
    .chk_fault(chk_fault), .chk_attr(chk_attr), .irq(irq));

  core_access_model u_core_access_model (
    .clk(clk), .arst_n(arst_n), .acc_valid(acc_valid), .acc_req(acc_req),
    .chk_valid(chk_valid), .chk_fault(chk_fault), .chk_attr(chk_attr));

  task automatic wrap_up;
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge clk);
    awaddr <= a;
    awprot <= p;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, input logic [2:0] p);
    @(posedge clk);
    araddr <= a;
    arprot <= p;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic acc(input logic [31:0] a, input logic ins, input logic pr, input logic vec,
                     input logic neg, input logic f_exp);
    region_protection_pkg::acc_req_t r;
    logic v;
    logic f;
    r = '{addr: a, write: 1'b0, instr: ins, priv: pr, vector_fetch: vec, neg_priority: neg};
    u_core_access_model.issue(r, v, f, at);
    check_bit(v, 1'b1);
    check_bit(f, f_exp);
  endtask : acc

  task automatic t_reset_regs;
    axi_rd(`ADDR_TYPE_INFO, 3'h1);
    check_word(rd, 32'h00000800);
    check_word({24'h0, rd[23:16]}, 32'h0);
    check_bit(rd[0], 1'b0);
    axi_rd(32'he000edbc, 3'h1);
    check_word({30'h0, rs}, 32'h3);
    axi_wr(`ADDR_CONTROL, 32'h7, 3'h0);
    check_word({30'h0, rs}, 32'h2);
    axi_rd(`ADDR_CONTROL, 3'h1);
    check_word(rd, 32'h0);
    axi_wr(`ADDR_CONTROL, 32'hfffffff8, 3'h1);
    axi_rd(`ADDR_CONTROL, 3'h1);
    check_word(rd, 32'h0);
  endtask : t_reset_regs

  task automatic t_default_map;
    acc(32'h20000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(32'he0001000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check_bit(at.ordered, 1'b1);
    check_bit(at.shareable, 1'b1);
    check_word({30'h0, at.mem_type}, {30'h0, region_protection_pkg::MT_STRONG});
  endtask : t_default_map

  task automatic t_regions;
    axi_wr(`ADDR_REGION_BASE, 32'h20000000, 3'h1);
    axi_wr(`ADDR_REGION_ATTR, 32'h03000017, 3'h1);
    axi_wr(`ADDR_BASE_ALIAS_ONE, 32'h20000011, 3'h1);
    axi_wr(`ADDR_ATTR_ALIAS_TWO, 32'h00000013, 3'h1);
    check_word({30'h0, rs}, 32'h0);
    axi_rd(`ADDR_REGION_SELECT, 3'h1);
    check_word(rd, 32'h1);
    axi_rd(`ADDR_BASE_ALIAS_THREE, 3'h1);
    check_word(rd, 32'h20000001);
    axi_rd(`ADDR_REGION_ATTR, 3'h1);
    check_word(rd, 32'h00000013);
    axi_wr(`ADDR_BASE_ALIAS_TWO, 32'h30000012, 3'h1);
    axi_wr(`ADDR_ATTR_ALIAS_THREE, 32'h13000017, 3'h1);
    axi_rd(`ADDR_ATTR_ALIAS_ONE, 3'h1);
    check_word(rd, 32'h13000017);
  endtask : t_regions

  task automatic t_enabled;
    axi_wr(`ADDR_CONTROL, 32'h1, 3'h1);
    acc(32'h20000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    check_word({29'h0, at.region_num}, 32'h1);
    acc(32'h20000800, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check_word({29'h0, at.region_num}, 32'h0);
    acc(32'h40000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'h40000000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    acc(32'he000e100, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(32'h00000000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(32'h30000000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check_word({29'h0, at.region_num}, 32'h2);
    axi_wr(`ADDR_CONTROL, 32'h5, 3'h1);
    acc(32'h40000000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    check_bit(at.background, 1'b1);
    acc(32'h40000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'h40000000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    axi_wr(`ADDR_CONTROL, 32'h7, 3'h1);
    acc(32'h40000000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    axi_wr(`ADDR_CONTROL, 32'h0, 3'h1);
    acc(32'h40000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask : t_enabled

  // faults so far left both status bits set with the mask still clear
  task automatic t_irq;
    check_bit(irq, 1'b0);
    axi_rd(`ADDR_IRQ_STATUS, 3'h1);
    check_word(rd, 32'h3);
    axi_wr(`ADDR_IRQ_MASK, 32'h1, 3'h1);
    repeat (2) @(posedge clk);
    #1;
    check_bit(irq, 1'b1);
    axi_wr(`ADDR_IRQ_STATUS, 32'h3, 3'h1);
    repeat (2) @(posedge clk);
    #1;
    check_bit(irq, 1'b0);
    axi_rd(`ADDR_IRQ_STATUS, 3'h1);
    check_word(rd, 32'h0);
  endtask : t_irq

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up;
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset_regs;
    t_default_map;
    t_regions;
    t_enabled;
    t_irq;
    wrap_up;
  end
endmodule : tb_region_protection_unit
